// File: design/arcu_pkg.sv
// Purpose: Shared constants for the data operation unit.
// Assumes: 32-bit register port, one word per register.
// Notes:   Offsets and field positions are used by design and bench.
package arcu_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_CLEAR   = 8'h08;
  localparam logic [7:0] OFS_INPUT   = 8'h0C;
  localparam logic [7:0] OFS_REF0    = 8'h10;
  localparam logic [7:0] OFS_REF1    = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h18;
  // Control field positions.
  localparam int CTL_OPSEL_LO = 0;
  localparam int CTL_WIDTH    = 3;
  localparam int CTL_DET_LO   = 4;
  localparam int CTL_STOP     = 7;
  // Status bit positions.
  localparam int ST_DETECT = 0;
  localparam int ST_OVF    = 1;
  localparam int ST_UNF    = 2;
  // Reset values.
  localparam logic [7:0]  CONTROL_RST = 8'h00;
  localparam logic [31:0] DATA_RST    = 32'h0000_0000;
  // Operation select codes.
  localparam logic [1:0] OP_COMPARE = 2'h0;
  localparam logic [1:0] OP_ADD     = 2'h1;
  localparam logic [1:0] OP_SUB     = 2'h2;
  // Detection condition codes.
  localparam logic [2:0] DET_NE  = 3'h0;
  localparam logic [2:0] DET_EQ  = 3'h1;
  localparam logic [2:0] DET_LT  = 3'h2;
  localparam logic [2:0] DET_GT  = 3'h3;
  localparam logic [2:0] DET_IN  = 3'h4;
  localparam logic [2:0] DET_OUT = 3'h5;
endpackage

// File: design/arcu_unit.sv
// Purpose: Data operation unit comparing, adding or subtracting operands.
// Assumes: Register port strobes are one cycle and never overlap.
// Notes:   Results show on the cycle after the operand write.
`timescale 1ns/1ps

module arcu_unit
  import arcu_pkg::*;
#(
  parameter int DATA_W = 32  // Register data width.
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // Register port.
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Event and interrupt outputs.
  output logic             event_out,
  output logic             irq_pulse,
  output logic             irq
);
  // Only a 32-bit register word is served; the narrow mode is a field, not a width.
  if (DATA_W != 32) begin : g_width_check
    $error("DATA_W must be 32.");
  end

  // Register map, all words on a 32-bit port:
  //   control  - operation select, width, condition and stop bits.
  //   status   - sticky detect, overflow and underflow flags; writes are ignored.
  //   clear    - write ones to drop status flags; reads return zero.
  //   input    - operand; a write here is what starts an operation.
  //   ref zero - first reference, and the accumulator for add and subtract.
  //   ref one  - upper bound for the two range tests.
  //   enable   - interrupt enables in the status layout.
  // Unmapped offsets read as zero and swallow writes.
  //
  // The datapath looks at the write data in the same cycle as the strobe, so
  // a result never waits for a copy of the operand to be stored first. The
  // cost is a long combinational path from the register port to the flags,
  // which is acceptable at the low system clock this block runs on.

  logic [7:0]  control;        // Operation control register.
  logic [2:0]  status;         // Sticky result flags.
  logic [2:0]  irq_en;         // Interrupt enables, status layout.
  logic [31:0] operand_input;  // Operand register.
  logic [31:0] reference_zero; // Reference or accumulator.
  logic [31:0] reference_one;  // Upper range bound.
  logic [2:0]  event_now;      // Events of the current operation.
  logic [31:0] next_ref0;      // Arithmetic result.
  logic        start;          // Operand written while running.

  logic [1:0] op_sel;
  logic       wide;
  logic [2:0] det_sel;
  logic       stopped;
  assign op_sel  = control[CTL_OPSEL_LO +: 2];
  assign wide    = control[CTL_WIDTH];
  assign det_sel = control[CTL_DET_LO +: 3];
  assign stopped = control[CTL_STOP];

  // An operand write starts one operation unless the unit is stopped.
  assign start = reg_wr && (reg_addr == OFS_INPUT) && !stopped;

  // In narrow mode all three operands are cut to their low halves and
  // zero-extended, so one 33-bit adder serves both widths; the carry or
  // borrow is then picked from bit 16 or bit 32.
  // Combinational datapath on the incoming operand and the references.
  always_comb begin
    logic [31:0] a;
    logic [31:0] r0;
    logic [31:0] r1;
    logic [32:0] sum;
    logic [32:0] dif;
    logic        lt0;
    logic        gt0;
    logic        gt1;
    logic        hit;
    hit = 1'b0;
    a   = wide ? reg_wdata : {16'h0000, reg_wdata[15:0]};
    r0  = wide ? reference_zero : {16'h0000, reference_zero[15:0]};
    r1  = wide ? reference_one : {16'h0000, reference_one[15:0]};
    sum = {1'b0, r0} + {1'b0, a};
    dif = {1'b0, r0} - {1'b0, a};
    lt0 = a < r0;
    gt0 = a > r0;
    gt1 = a > r1;
    unique case (det_sel)
      DET_NE:  hit = a != r0;
      DET_EQ:  hit = a == r0;
      DET_LT:  hit = lt0;
      DET_GT:  hit = gt0;
      DET_IN:  hit = gt0 && (a < r1);
      DET_OUT: hit = lt0 || gt1;
      default: hit = 1'b0;
    endcase
    event_now = 3'h0;
    next_ref0 = reference_zero;
    if (op_sel == OP_COMPARE) begin
      event_now[ST_DETECT] = hit;
    end else if (op_sel == OP_ADD) begin
      // Overflow is the carry out of the selected width.
      event_now[ST_OVF] = wide ? sum[32] : sum[16];
      next_ref0 = wide ? sum[31:0] : {16'h0000, sum[15:0]};
    end else if (op_sel == OP_SUB) begin
      // Underflow is the borrow out of the selected width.
      event_now[ST_UNF] = wide ? dif[32] : dif[16];
      next_ref0 = wide ? dif[31:0] : {16'h0000, dif[15:0]};
    end
  end

  // A write to reference zero outranks an accumulate, although the port
  // never carries both in one cycle.
  // Control, enable and data registers.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      control        <= CONTROL_RST;
      irq_en         <= 3'h0;
      operand_input  <= DATA_RST;
      reference_zero <= DATA_RST;
      reference_one  <= DATA_RST;
    end else if (reg_wr) begin
      if (reg_addr == OFS_CONTROL) begin
        control <= reg_wdata[7:0];
      end
      if (reg_addr == OFS_IRQ_EN) begin
        irq_en <= reg_wdata[2:0];
      end
      if (reg_addr == OFS_INPUT) begin
        operand_input <= reg_wdata;
      end
      if (reg_addr == OFS_REF0) begin
        reference_zero <= reg_wdata;
      end else if (start && (op_sel != OP_COMPARE)) begin
        reference_zero <= next_ref0;
      end
      if (reg_addr == OFS_REF1) begin
        reference_one <= reg_wdata;
      end
    end
  end

  // A clear and an operation never share a cycle on this port, but the
  // set term is still ordered last so that an event can never be lost.
  // Sticky status; a new event wins over a clear in the same cycle.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      status <= 3'h0;
    end else begin
      logic [2:0] clr;
      logic [2:0] set;
      clr = (reg_wr && reg_addr == OFS_CLEAR) ? reg_wdata[2:0] : 3'h0;
      set = start ? event_now : 3'h0;
      status <= (status & ~clr) | set;
    end
  end

  // The level interrupt is worked out from the next status value, so it
  // rises in the same cycle as the pulses instead of one cycle later.
  // One-cycle event pulses and the level interrupt.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      event_out <= 1'b0;
      irq_pulse <= 1'b0;
      irq       <= 1'b0;
    end else begin
      event_out <= start && (event_now != 3'h0);
      irq_pulse <= start && (event_now != 3'h0);
      irq       <= |(((status & ~((reg_wr && reg_addr == OFS_CLEAR) ? reg_wdata[2:0] : 3'h0))
                    | (start ? event_now : 3'h0)) & irq_en);
    end
  end

  // Reads have no side effects, so software may poll status freely.
  // Read data stand in the cycle after the read strobe.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_CONTROL: reg_rdata <= {24'h000000, control};
        OFS_STATUS:  reg_rdata <= {29'h0, status};
        OFS_INPUT:   reg_rdata <= operand_input;
        OFS_REF0:    reg_rdata <= reference_zero;
        OFS_REF1:    reg_rdata <= reference_one;
        OFS_IRQ_EN:  reg_rdata <= {29'h0, irq_en};
        default:     reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // Checks.
  // The named sequences below describe the cycle in which an operation or a
  // clear is accepted; each property built on one then states what must show one cycle later.
  // Operand write accepted with compare selected.
  sequence s_cmp_go;
    start && (op_sel == OP_COMPARE);
  endsequence

  // Operand write accepted with add selected.
  sequence s_add_go;
    start && (op_sel == OP_ADD);
  endsequence

  // Operand write accepted with subtract selected.
  sequence s_sub_go;
    start && (op_sel == OP_SUB);
  endsequence

  // Write to the clear register with the detect bit set.
  sequence s_detect_clear;
    reg_wr && (reg_addr == OFS_CLEAR) && reg_wdata[ST_DETECT];
  endsequence

  chk_add_overflow: assert property (@(posedge sys_clk) disable iff (!nrst)
    (start && op_sel == OP_ADD && !wide && ({1'b0, reference_zero[15:0]}
      + {1'b0, reg_wdata[15:0]} > 17'h0FFFF)) |=> status[ST_OVF])
    else $error("Overflow flag missing.");
  chk_event_irq: assert property (@(posedge sys_clk) disable iff (!nrst)
    event_out == irq_pulse) else $error("Event and interrupt differ.");
  chk_flag_sticky: assert property (@(posedge sys_clk) disable iff (!nrst)
    (status[ST_DETECT] && !(reg_wr && reg_addr == OFS_CLEAR)) |=> status[ST_DETECT])
    else $error("Flag dropped without clear.");
  chk_stop_holds: assert property (@(posedge sys_clk) disable iff (!nrst)
    (reg_wr && reg_addr == OFS_INPUT && stopped) |=> !event_out)
    else $error("Stopped unit produced event.");
  chk_eq_detect: assert property (@(posedge sys_clk) disable iff (!nrst)
    (start && op_sel == OP_COMPARE && det_sel == DET_EQ && wide
      && reg_wdata == reference_zero) |=> (event_out && status[ST_DETECT]))
    else $error("Equal not detected.");
  chk_sub_under: assert property (@(posedge sys_clk) disable iff (!nrst)
    (start && op_sel == OP_SUB && wide && reg_wdata > reference_zero) |=> status[ST_UNF])
    else $error("Underflow flag missing.");
  chk_pulse_single: assert property (@(posedge sys_clk) disable iff (!nrst)
    irq_pulse |=> !irq_pulse) else $error("Pulse longer than one cycle.");
  chk_acc_result: assert property (@(posedge sys_clk) disable iff (!nrst)
    (start && op_sel == OP_ADD && wide && reg_addr == OFS_INPUT)
      |=> reference_zero == $past(reference_zero) + $past(reg_wdata))
    else $error("Accumulator not updated.");

  // Mismatch in wide mode sets detect.
  chk_ne_detect: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_cmp_go ##0 (det_sel == DET_NE && wide && reg_wdata != reference_zero)
      |=> status[ST_DETECT])
    else $error("Mismatch not detected.");

  // Operand below reference zero in wide mode sets detect.
  chk_lt_detect: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_cmp_go ##0 (det_sel == DET_LT && wide && reg_wdata < reference_zero)
      |=> status[ST_DETECT])
    else $error("Less not detected.");

  // Operand above reference zero in wide mode sets detect.
  chk_gt_detect: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_cmp_go ##0 (det_sel == DET_GT && wide && reg_wdata > reference_zero)
      |=> status[ST_DETECT])
    else $error("Greater not detected.");

  // Operand strictly between the references sets detect.
  chk_range_inside: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_cmp_go ##0 (det_sel == DET_IN && wide && reg_wdata > reference_zero
      && reg_wdata < reference_one) |=> status[ST_DETECT])
    else $error("In range not detected.");

  // Operand outside the references sets detect.
  chk_range_outside: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_cmp_go ##0 (det_sel == DET_OUT && wide && (reg_wdata < reference_zero
      || reg_wdata > reference_one)) |=> status[ST_DETECT])
    else $error("Out of range not detected.");

  // Prohibited condition codes never raise an event.
  chk_bad_code: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_cmp_go ##0 (det_sel > DET_OUT)
      |=> !event_out)
    else $error("Prohibited code raised an event.");

  // Wide addition past the top sets overflow.
  chk_wide_overflow: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_add_go ##0 (wide && ({1'b0, reference_zero} + {1'b0, reg_wdata}) > 33'h0FFFFFFFF)
      |=> status[ST_OVF])
    else $error("Wide overflow flag missing.");

  // Narrow addition inside the range raises nothing.
  chk_add_clean: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_add_go ##0 (!wide && ({1'b0, reference_zero[15:0]} + {1'b0, reg_wdata[15:0]})
      <= 17'h0FFFF) |=> !event_out)
    else $error("Overflow without carry.");

  // Narrow subtraction below zero sets underflow.
  chk_narrow_under: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_sub_go ##0 (!wide && reg_wdata[15:0] > reference_zero[15:0])
      |=> status[ST_UNF])
    else $error("Narrow underflow flag missing.");

  // Wide subtraction that stays at or above zero raises nothing.
  chk_sub_clean: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_sub_go ##0 (wide && reg_wdata <= reference_zero)
      |=> !event_out)
    else $error("Underflow without borrow.");

  // The level interrupt follows enabled status bits.
  chk_irq_level: assert property (@(posedge sys_clk) disable iff (!nrst)
    irq == |(status & $past(irq_en)))
    else $error("Interrupt level wrong.");

  // A clear of the detect bit drops it.
  chk_detect_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_detect_clear ##0 !start
      |=> !status[ST_DETECT])
    else $error("Detect flag not cleared.");

  // A stopped unit leaves the accumulator alone.
  chk_stop_keeps: assert property (@(posedge sys_clk) disable iff (!nrst)
    (reg_wr && reg_addr == OFS_INPUT && stopped)
      |=> $stable(reference_zero))
    else $error("Stopped unit changed reference zero.");

  // No operation, no event.
  chk_idle_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
    !start
      |=> !event_out)
    else $error("Event without operation.");

  // Narrow add results are zero-extended.
  chk_narrow_result: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_add_go ##0 !wide
      |=> reference_zero[31:16] == 16'h0000)
    else $error("Narrow result not zero-extended.");

  // Narrow equal compare uses the low halves only.
  chk_narrow_detect: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_cmp_go ##0 (det_sel == DET_EQ && !wide && reg_wdata[15:0] == reference_zero[15:0])
      |=> status[ST_DETECT])
    else $error("Narrow match not detected.");

  // Wide subtraction replaces reference zero with the difference.
  chk_sub_result: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_sub_go ##0 wide
      |=> reference_zero == $past(reference_zero) - $past(reg_wdata))
    else $error("Difference not stored.");

  // The operand register keeps what was written.
  chk_input_store: assert property (@(posedge sys_clk) disable iff (!nrst)
    (reg_wr && reg_addr == OFS_INPUT)
      |=> operand_input == $past(reg_wdata))
    else $error("Operand not stored.");

  // Reference one keeps what was written.
  chk_ref_one_store: assert property (@(posedge sys_clk) disable iff (!nrst)
    (reg_wr && reg_addr == OFS_REF1)
      |=> reference_one == $past(reg_wdata))
    else $error("Reference one not stored.");

  // An event pulse always comes with a set status flag.
  chk_event_flag: assert property (@(posedge sys_clk) disable iff (!nrst)
    event_out
      |-> status != 3'h0)
    else $error("Event without status flag.");
endmodule

// File: tb/tb_data_operation_unit.sv
// Purpose: Self-checking bench for the data operation unit.
// Assumes: Register map and one-cycle answers as in the design notes.
// Notes:   Table rows first, then reset, read-only, stop, sticky and mask cases.
`timescale 1ns/1ps
module tb_data_operation_unit;
  import arcu_pkg::*;
  // One table case: setup, operand, expected status and reference zero.
  typedef struct packed {
    logic [7:0]  ctl;
    logic [31:0] r0;
    logic [31:0] r1;
    logic [31:0] din;
    logic [2:0]  st;
    logic [31:0] res;
  } arcu_row_s;
  logic        sys_clk;     // Bench clock.
  logic        nrst;        // Active-low reset.
  logic [7:0]  reg_addr;    // Register address.
  logic [31:0] reg_wdata;   // Write data.
  logic        reg_wr;      // Write strobe.
  logic        reg_rd;      // Read strobe.
  logic [31:0] reg_rdata;   // Read data.
  logic        event_out;   // Event-link pulse.
  logic        irq_pulse;   // Interrupt pulse.
  logic        irq;         // Interrupt level.
  int          mismatches;  // Failed compares.
  int          check_count; // All compares.
  int          cycles;      // Timeout counter.
  arcu_row_s   rows [16];   // Ordinary cases.
  arcu_unit arcu_unit_i (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .event_out(event_out), .irq_pulse(irq_pulse), .irq(irq));
  // Free-running 20 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Compare and count.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One-cycle write strobe; returns just after the edge that took it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // One-cycle read strobe; data are looked at in the following cycle only.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // Verdict and end of run.
  task automatic report_and_stop;
    if (mismatches == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Cut a hang short.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // Main sequence.
  initial begin
    {nrst, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {mismatches, check_count, cycles} = '0;
    rows = '{'{8'h00, 32'h1234, 0, 32'hFFFF1234, 3'h0, 32'h1234},
      '{8'h08, 32'h1234, 0, 32'hFFFF1234, 3'h1, 32'h1234},
      '{8'h18, 5, 0, 5, 3'h1, 5}, '{8'h28, 10, 0, 9, 3'h1, 10},
      '{8'h38, 10, 0, 10, 3'h0, 10}, '{8'h48, 10, 20, 20, 3'h0, 10},
      '{8'h40, 10, 20, 32'h10000F, 3'h1, 10}, '{8'h58, 10, 20, 21, 3'h1, 10},
      '{8'h68, 10, 20, 5, 3'h0, 10}, '{8'h01, 32'hFFFF, 0, 1, 3'h2, 0},
      '{8'h09, 32'hFFFF, 0, 1, 3'h0, 32'h10000},
      '{8'h09, 32'hFFFFFFFF, 0, 2, 3'h2, 1}, '{8'h02, 0, 0, 1, 3'h4, 32'hFFFF},
      '{8'h0A, 5, 0, 5, 3'h0, 0}, '{8'h0A, 0, 0, 1, 3'h4, 32'hFFFFFFFF},
      '{8'h58, 10, 20, 5, 3'h1, 10}};
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    wr(OFS_IRQ_EN, 32'h7);
    foreach (rows[i]) begin
      wr(OFS_CONTROL, {24'h0, rows[i].ctl});
      wr(OFS_REF0, rows[i].r0);
      wr(OFS_REF1, rows[i].r1);
      wr(OFS_CLEAR, 32'h7);
      wr(OFS_INPUT, rows[i].din);
      chk(event_out, rows[i].st != 3'h0);
      chk(irq_pulse, rows[i].st != 3'h0);
      chk(irq, rows[i].st != 3'h0);
      @(posedge sys_clk);
      #1;
      chk(event_out | irq_pulse, 1'b0);
      rd_chk(OFS_STATUS, {29'h0, rows[i].st});
      rd_chk(OFS_REF0, rows[i].res);
      rd_chk(OFS_INPUT, rows[i].din);
      rd_chk(OFS_REF1, rows[i].r1);
    end
    // A reset in mid-run drops irq and returns control, reference zero and the operand to their reset values.
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    #1;
    chk(irq, 1'b0);
    rd_chk(OFS_CONTROL, {24'h0, CONTROL_RST});
    rd_chk(OFS_REF0, DATA_RST);
    rd_chk(OFS_INPUT, DATA_RST);
    wr(OFS_STATUS, 32'hFF);
    rd_chk(OFS_STATUS, 32'h0);
    rd_chk(OFS_CLEAR, 32'h0);
    rd_chk(8'h1C, 32'h0);
    // Stopped unit keeps the operand but starts nothing.
    wr(OFS_IRQ_EN, 32'h7);
    wr(OFS_REF0, 5);
    wr(OFS_CONTROL, 32'h98);
    wr(OFS_INPUT, 5);
    chk(event_out, 1'b0);
    rd_chk(OFS_STATUS, 32'h0);
    rd_chk(OFS_INPUT, 5);
    // Sticky flag, masked and unmasked interrupt, then clear.
    wr(OFS_CONTROL, 32'h18);
    wr(OFS_INPUT, 5);
    wr(OFS_IRQ_EN, 32'h0);
    @(posedge sys_clk);
    #1;
    chk(irq, 1'b0);
    wr(OFS_INPUT, 6);
    rd_chk(OFS_STATUS, 32'h1);
    wr(OFS_IRQ_EN, 32'h1);
    @(posedge sys_clk);
    #1;
    chk(irq, 1'b1);
    wr(OFS_CLEAR, 32'h1);
    @(posedge sys_clk);
    #1;
    chk(irq, 1'b0);
    rd_chk(OFS_STATUS, 32'h0);
    report_and_stop();
  end
endmodule
